// *** etdcs_pkg.sv ***
/*
 etdcs_pkg: constants and carrier types for the transmit descriptor
 word-0 control/status handler.
 assumes: a 32-bit descriptor word layout, one clock domain.
*/
package etdcs_pkg;
	// descriptor word 0 field positions
	localparam int unsigned LastSegBit = 29;
	localparam int unsigned FirstSegBit = 28;
	localparam int unsigned TsEnBit = 25;
	localparam int unsigned CsumHi = 23;
	localparam int unsigned CsumLo = 22;
	localparam int unsigned EndRingBit = 21;
	localparam int unsigned ChainBit = 20;
	localparam int unsigned TsCapBit = 17;
	localparam int unsigned IpHdrErrBit = 16;
	// descriptor word 1 second buffer size field
	localparam int unsigned Buf2Hi = 28;
	localparam int unsigned Buf2Lo = 16;
	// checksum control encodings
	localparam logic [1:0] CsumOff = 2'h0;
	localparam logic [1:0] CsumIpOnly = 2'h1;
	localparam logic [1:0] CsumNoPseudo = 2'h2;
	localparam logic [1:0] CsumFull = 2'h3;
	// header checks
	localparam logic [3:0] Ipv4MinIhl = 4'h5;
	localparam logic [7:0] Ipv6HdrBytes = 8'h28;
	localparam logic [15:0] EtherTypeV4 = 16'h0800;
	localparam logic [15:0] EtherTypeV6 = 16'h86dd;
	localparam logic [3:0] IpVer4 = 4'h4;
	localparam logic [3:0] IpVer6 = 4'h6;
	// register map (word offsets in bytes)
	localparam logic [3:0] RegStatus = 4'h0;
	localparam logic [3:0] RegClear = 4'h4;
	localparam logic [3:0] RegEnable = 4'h8;
	localparam logic [3:0] RegLastCtl = 4'hc;
	localparam logic [31:0] ResetZero = 32'h0000_0000;
	// interrupt bit positions
	localparam int unsigned IrqTsBit = 0;
	localparam int unsigned IrqHdrErrBit = 1;
	localparam int unsigned IrqWrapBit = 2;

	typedef struct packed {
		logic ipHdrCsum;
		logic payloadCsum;
		logic pseudoHdrCsum;
	} etdcs_csum_t;

	typedef struct packed {
		logic [15:0] etherType;
		logic [3:0] ipVersion;
		logic [3:0] ipv4Ihl;
		logic [7:0] hdrBytes;
	} etdcs_hdr_t;

	typedef struct packed {
		logic valid;
		logic [31:0] ts_lo;
		logic [31:0] ts_hi;
	} etdcs_ts_t;
endpackage

// *** etdcs_ctrl.sv ***
/*
 etdcs_ctrl: decodes the control bits of transmit descriptor word 0
 (checksum selection, ring wrap, chaining, timestamp request) and builds
 the status bits written back (timestamp captured, ip header error).
 assumes: one descriptor word presented per descValid pulse; header
 facts and timestamps arrive as one-cycle strobes from the transmitter.
*/
`timescale 1ns/1ps
module etdcs_ctrl (
	input wire logic mclk,
	input wire logic rst,
	input wire logic descValid,
	input wire logic [31:0] txDescWord0,
	input wire logic [31:0] txDescWord1,
	input wire logic [31:0] secondAddr,
	input wire logic [31:0] curDescAddr,
	input wire logic [31:0] listBaseAddr,
	input wire logic [31:0] descStride,
	input wire logic hdrValid,
	input wire etdcs_pkg::etdcs_hdr_t hdrInfo,
	input wire etdcs_pkg::etdcs_ts_t tsIn,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output etdcs_pkg::etdcs_csum_t csumSel,
	output logic tsRequest,
	output logic [31:0] nextDescAddr,
	output logic [12:0] secondBufSize,
	output logic wbValid,
	output logic [31:0] txDescWord0Wb,
	output logic [31:0] txDescWord2,
	output logic [31:0] txDescWord3,
	output logic [31:0] regRdata,
	output logic irq
);
	etdcs_pkg::etdcs_csum_t csum_r;
	logic tsReq_r;
	logic [31:0] nextAddr_r;
	logic [12:0] buf2_r;
	logic [1:0] frameCode_r;
	logic frameTs_r;
	logic [31:0] word0_r;
	logic hdrErr_r;
	logic [31:0] wbWord_r;
	logic wbValid_r;
	logic [31:0] ts2_r;
	logic [31:0] ts3_r;
	logic [2:0] irqStat_r;
	logic [2:0] irqEn_r;
	logic [31:0] rdata_r;
	logic irq_r;
	logic [2:0] irqSet;
	logic hdrBad;
	logic firstSeg;
	logic [1:0] codeNow;

	function automatic etdcs_pkg::etdcs_csum_t decodeCsum(
		input logic [1:0] code
	);
		etdcs_pkg::etdcs_csum_t c;
		c = '0;
		unique case (code)
			etdcs_pkg::CsumOff: c = '0;
			etdcs_pkg::CsumIpOnly: c.ipHdrCsum = 1'b1;
			etdcs_pkg::CsumNoPseudo: begin
				c.ipHdrCsum = 1'b1;
				c.payloadCsum = 1'b1;
			end
			etdcs_pkg::CsumFull: begin
				c.ipHdrCsum = 1'b1;
				c.payloadCsum = 1'b1;
				c.pseudoHdrCsum = 1'b1;
			end
		endcase
		return c;
	endfunction

	// the header checks are pure combinational tests on the strobed facts
	function automatic logic checkHdr(input etdcs_pkg::etdcs_hdr_t h);
		logic bad;
		logic [7:0] ihlBytes;
		bad = 1'b0;
		ihlBytes = {2'h0, h.ipv4Ihl, 2'h0};
		if (h.etherType == etdcs_pkg::EtherTypeV4) begin
			if (h.ipVersion != etdcs_pkg::IpVer4)
				bad = 1'b1;
			if (h.ipv4Ihl < etdcs_pkg::Ipv4MinIhl)
				bad = 1'b1;
			if (ihlBytes != h.hdrBytes)
				bad = 1'b1;
		end else if (h.etherType == etdcs_pkg::EtherTypeV6) begin
			if (h.ipVersion != etdcs_pkg::IpVer6)
				bad = 1'b1;
			if (h.hdrBytes != etdcs_pkg::Ipv6HdrBytes)
				bad = 1'b1;
		end
		return bad;
	endfunction

	// end of ring is tested first, so it wins when both flags are set
	function automatic logic [31:0] pickNext(
		input logic [31:0] word0,
		input logic [31:0] base,
		input logic [31:0] chained,
		input logic [31:0] sequential
	);
		if (word0[etdcs_pkg::EndRingBit])
			return base;
		if (word0[etdcs_pkg::ChainBit])
			return chained;
		return sequential;
	endfunction

	// status bits overlay the stored control word; others pass through
	function automatic logic [31:0] buildWb(
		input logic [31:0] word,
		input logic tsCaptured,
		input logic hdrError
	);
		logic [31:0] w;
		w = word;
		w[etdcs_pkg::TsCapBit] = tsCaptured;
		w[etdcs_pkg::IpHdrErrBit] = hdrError;
		return w;
	endfunction

	assign firstSeg = txDescWord0[etdcs_pkg::FirstSegBit];
	assign codeNow = txDescWord0[etdcs_pkg::CsumHi:etdcs_pkg::CsumLo];
	assign hdrBad = hdrValid && checkHdr(hdrInfo);

	// first segment latches per-frame controls; later segments keep them
	always_ff @(posedge mclk) begin
		if (rst)
			frameCode_r <= etdcs_pkg::CsumOff;
		else if (descValid && firstSeg)
			frameCode_r <= codeNow;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			frameTs_r <= 1'b0;
		else if (descValid && firstSeg)
			frameTs_r <= txDescWord0[etdcs_pkg::TsEnBit];
	end

	// reserved bits 24 and 19:18 steer no control; they pass through to the write-back and readback
	always_ff @(posedge mclk) begin
		if (rst)
			csum_r <= '0;
		else if (descValid && firstSeg)
			csum_r <= decodeCsum(codeNow);
		else if (descValid)
			csum_r <= decodeCsum(frameCode_r);
	end

	always_ff @(posedge mclk) begin
		if (rst)
			tsReq_r <= 1'b0;
		else if (descValid && firstSeg)
			tsReq_r <= txDescWord0[etdcs_pkg::TsEnBit];
		else if (descValid)
			tsReq_r <= frameTs_r;
	end

	// the sequential step wraps silently at the top of the address space
	always_ff @(posedge mclk) begin
		if (rst)
			nextAddr_r <= etdcs_pkg::ResetZero;
		else if (descValid)
			nextAddr_r <= pickNext(txDescWord0, listBaseAddr, secondAddr,
				curDescAddr + descStride);
	end

	// chaining makes the second size a don't-care; it reads as zero
	always_ff @(posedge mclk) begin
		if (rst)
			buf2_r <= '0;
		else if (descValid && txDescWord0[etdcs_pkg::ChainBit])
			buf2_r <= 13'h0000;
		else if (descValid)
			buf2_r <= txDescWord1[etdcs_pkg::Buf2Hi:etdcs_pkg::Buf2Lo];
	end

	// kept for the write-back and for software to read back
	always_ff @(posedge mclk) begin
		if (rst)
			word0_r <= etdcs_pkg::ResetZero;
		else if (descValid)
			word0_r <= txDescWord0;
	end

	// sticky header error per frame; a new frame clears it, an event wins
	always_ff @(posedge mclk) begin
		if (rst)
			hdrErr_r <= 1'b0;
		else if (hdrBad)
			hdrErr_r <= 1'b1;
		else if (descValid && firstSeg)
			hdrErr_r <= 1'b0;
	end

	// write-back follows every frame end strobe, stamped or not
	always_ff @(posedge mclk) begin
		if (rst)
			wbValid_r <= 1'b0;
		else
			wbValid_r <= tsIn.valid;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			wbWord_r <= etdcs_pkg::ResetZero;
		else if (tsIn.valid)
			wbWord_r <= buildWb(word0_r, frameTs_r, hdrErr_r | hdrBad);
	end

	// words two and three keep the last stamp when none was asked for
	always_ff @(posedge mclk) begin
		if (rst) begin
			ts2_r <= etdcs_pkg::ResetZero;
			ts3_r <= etdcs_pkg::ResetZero;
		end else if (tsIn.valid && frameTs_r) begin
			ts2_r <= tsIn.ts_lo;
			ts3_r <= tsIn.ts_hi;
		end
	end

	// software reads bit 17 only in last-segment words
	assign irqSet = {
		descValid && txDescWord0[etdcs_pkg::EndRingBit],
		hdrBad,
		tsIn.valid && frameTs_r
	};

	// a set in the same cycle as a clear wins so no event is lost
	always_ff @(posedge mclk) begin
		if (rst)
			irqStat_r <= '0;
		else if (regWr && regAddr == etdcs_pkg::RegClear)
			irqStat_r <= (irqStat_r & ~regWdata[2:0]) | irqSet;
		else
			irqStat_r <= irqStat_r | irqSet;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			irqEn_r <= '0;
		else if (regWr && regAddr == etdcs_pkg::RegEnable)
			irqEn_r <= regWdata[2:0];
	end

	// the level output trails status and enable by one cycle
	always_ff @(posedge mclk) begin
		if (rst)
			irq_r <= 1'b0;
		else
			irq_r <= |(irqStat_r & irqEn_r);
	end

	// read data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (rst || !regRd) begin
			rdata_r <= etdcs_pkg::ResetZero;
		end else begin
			unique case (regAddr)
				etdcs_pkg::RegStatus: rdata_r <= {29'h0, irqStat_r};
				etdcs_pkg::RegEnable: rdata_r <= {29'h0, irqEn_r};
				etdcs_pkg::RegLastCtl: rdata_r <= word0_r;
				default: rdata_r <= etdcs_pkg::ResetZero;
			endcase
		end
	end

	assign csumSel = csum_r;
	assign tsRequest = tsReq_r;
	assign nextDescAddr = nextAddr_r;
	assign secondBufSize = buf2_r;
	assign wbValid = wbValid_r;
	assign txDescWord0Wb = wbWord_r;
	assign txDescWord2 = ts2_r;
	assign txDescWord3 = ts3_r;
	assign regRdata = rdata_r;
	assign irq = irq_r;
endmodule // etdcs_ctrl

// *** etdcs_ctrl_chk.sv ***
/* etdcs_ctrl_chk: port assertions for etdcs_ctrl.
 assumes: one clock mclk, synchronous reset rst. */
`timescale 1ns/1ps
module etdcs_ctrl_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic descValid,
	input wire logic [31:0] txDescWord0,
	input wire logic [31:0] secondAddr,
	input wire logic [31:0] listBaseAddr,
	input wire etdcs_pkg::etdcs_ts_t tsIn,
	input wire etdcs_pkg::etdcs_csum_t csumSel,
	input wire logic tsRequest,
	input wire logic [31:0] nextDescAddr,
	input wire logic [12:0] secondBufSize,
	input wire logic wbValid,
	input wire logic [31:0] txDescWord0Wb
);
	wire logic [1:0] code = txDescWord0[23:22];
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_first; descValid && txDescWord0[28]; endsequence
	sequence s_later; descValid && !txDescWord0[28]; endsequence
	property p_cs0; s_first ##0 code == 2'h0 |=> csumSel == 3'h0; endproperty
	a_cs0: assert property (p_cs0) else $error("csum off");
	property p_cs1; s_first ##0 code == 2'h1 |=> csumSel == 3'h4; endproperty
	a_cs1: assert property (p_cs1) else $error("csum ip");
	property p_cs2; s_first ##0 code == 2'h2 |=> csumSel == 3'h6; endproperty
	a_cs2: assert property (p_cs2) else $error("csum part");
	property p_cs3; s_first ##0 code == 2'h3 |=> csumSel == 3'h7; endproperty
	a_cs3: assert property (p_cs3) else $error("csum full");
	property p_keep;
		s_later |=> $stable(csumSel) && $stable(tsRequest); endproperty
	a_keep: assert property (p_keep) else $error("ctl kept");
	property p_ts; s_first |=> tsRequest == $past(txDescWord0[25]); endproperty
	a_ts: assert property (p_ts) else $error("ts request");
	property p_ring; descValid && txDescWord0[21]
		|=> nextDescAddr == $past(listBaseAddr); endproperty
	a_ring: assert property (p_ring) else $error("ring");
	property p_chain; descValid && txDescWord0[21:20] == 2'h1
		|=> nextDescAddr == $past(secondAddr) && secondBufSize == 13'h0;
	endproperty
	a_chain: assert property (p_chain) else $error("chain");
	property p_wb; tsIn.valid && tsRequest && !descValid
		|=> wbValid && txDescWord0Wb[17]; endproperty
	a_wb: assert property (p_wb) else $error("ts status");
endmodule // etdcs_ctrl_chk
bind etdcs_ctrl etdcs_ctrl_chk chk_u (.*);

// *** etdcs_host.sv ***
/* etdcs_host: host software model building transmit descriptors.
 assumes: caller has seeded $urandom; one descriptor per send. */
`timescale 1ns/1ps
module etdcs_host (
	input wire logic mclk,
	output logic descValid,
	output logic [31:0] txDescWord0,
	output logic [31:0] txDescWord1,
	output logic [31:0] secondAddr,
	output logic [31:0] curDescAddr,
	output logic [31:0] listBaseAddr,
	output logic [31:0] descStride
);
	logic [31:0] w1, sa, ca, lb;
	initial begin
		descValid = 1'b0;
		{txDescWord0, txDescWord1, secondAddr, curDescAddr} = '0;
		{listBaseAddr, descStride} = '0;
	end
	task automatic send(input logic [31:0] w0);
		w1 = $urandom;
		sa = $urandom;
		ca = $urandom;
		lb = $urandom;
		@(posedge mclk);
		descValid <= 1'b1;
		txDescWord0 <= w0 & 32'hfef3ffff;
		txDescWord1 <= w1;
		secondAddr <= sa;
		curDescAddr <= ca;
		listBaseAddr <= lb;
		descStride <= 32'h10;
		@(posedge mclk);
		descValid <= 1'b0;
		// stale word 0 and second address inverted so they never pass for live ones
		txDescWord0 <= ~w0;
		secondAddr <= ~sa;
	endtask
endmodule // etdcs_host

// *** tb.sv ***
/* tb: self-checking bench for etdcs_ctrl beside a host model.
 assumes: etdcs_pkg compiled first; checker bound to etdcs_ctrl. */
`timescale 1ns/1ps
module tb;
	logic mclk, rst, descValid, hdrValid, regWr, regRd, wbValid, irq, tsReq;
	logic [31:0] w0d, w1d, sad, cad, lbd, std, regWdata, regRdata, w, d;
	logic [31:0] nextDescAddr, txDescWord0Wb, txDescWord2, txDescWord3;
	logic [3:0] regAddr;
	logic [12:0] secondBufSize;
	etdcs_pkg::etdcs_hdr_t hdrInfo, h;
	etdcs_pkg::etdcs_ts_t tsIn;
	etdcs_pkg::etdcs_csum_t csumSel;
	int n_errors = 0, n_checks = 0, cyc = 0;
	etdcs_host host_u (.mclk(mclk), .descValid(descValid), .txDescWord0(w0d),
		.txDescWord1(w1d), .secondAddr(sad), .curDescAddr(cad),
		.listBaseAddr(lbd), .descStride(std));
	etdcs_ctrl dut_u (.mclk(mclk), .rst(rst), .descValid(descValid),
		.txDescWord0(w0d), .txDescWord1(w1d), .secondAddr(sad),
		.curDescAddr(cad), .listBaseAddr(lbd), .descStride(std),
		.hdrValid(hdrValid), .hdrInfo(hdrInfo), .tsIn(tsIn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .csumSel(csumSel), .tsRequest(tsReq),
		.nextDescAddr(nextDescAddr), .secondBufSize(secondBufSize),
		.wbValid(wbValid), .txDescWord0Wb(txDescWord0Wb),
		.txDescWord2(txDescWord2), .txDescWord3(txDescWord3),
		.regRdata(regRdata), .irq(irq));
	function automatic logic [31:0] expCsum(input logic [1:0] c);
		return {29'h0, c != 2'h0, c[1], c == 2'h3};
	endfunction
	function automatic logic expErr(input etdcs_pkg::etdcs_hdr_t x);
		if (x.etherType == 16'h0800)
			return x.ipVersion != 4'h4 || x.ipv4Ihl < 4'h5
				|| {2'h0, x.ipv4Ihl, 2'h0} != x.hdrBytes;
		if (x.etherType == 16'h86dd)
			return x.ipVersion != 4'h6 || x.hdrBytes != 8'h28;
		return 1'b0;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic regXfer(input logic wr, input logic [3:0] a,
		input logic [31:0] v);
		@(posedge mclk);
		{regWr, regRd} <= {wr, !wr};
		regAddr <= a;
		regWdata <= v;
		@(posedge mclk);
		{regWr, regRd} <= 2'h0;
		#1 d = regRdata;
	endtask
	task automatic frame(input logic [31:0] lo, hi);
		logic e;
		host_u.send(w);
		@(posedge mclk);
		hdrValid <= 1'b1;
		hdrInfo <= h;
		@(posedge mclk);
		hdrValid <= 1'b0;
		tsIn <= '{1'b1, lo, hi};
		@(posedge mclk);
		tsIn.valid <= 1'b0;
		#1 check("wb", wbValid, 32'h1);
		e = expErr(h);
		check("ihe", txDescWord0Wb[16], e);
		if (w[29])
			check("ts cap", txDescWord0Wb[17], w[25]);
		if (w[25])
			check("ts", {txDescWord3, txDescWord2} == {hi, lo}, 32'h1);
	endtask
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// run needs about 200 cycles; ceiling leaves ample margin
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		{rst, hdrValid, regWr, regRd, regAddr, regWdata} = {4'h8, 36'h0};
		hdrInfo = '0;
		tsIn = '0;
		w = $urandom(74043);
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		regXfer(1'b0, 4'h0, 32'h0);
		check("status", d, 32'h0);
		regXfer(1'b0, 4'h2, 32'h0);
		check("unmapped", d, 32'h0);
		for (int c = 0; c < 4; c++) begin
			w = $urandom | 32'h10000000;
			w[23:22] = 2'(c);
			host_u.send(w);
			#1 check("csum", 32'(csumSel), expCsum(2'(c)));
			check("ts req", tsReq, w[25]);
			w = ~w;
			host_u.send(w);
			#1 check("csum kept", 32'(csumSel), expCsum(~w[23:22]));
			check("ts kept", tsReq, !w[25]);
		end
		repeat (16) begin
			w = $urandom;
			host_u.send(w);
			#1 check("next", nextDescAddr, w[21] ? host_u.lb : w[20] ?
				host_u.sa : host_u.ca + 32'h10);
			check("size", secondBufSize,
				w[20] ? 32'h0 : 32'(host_u.w1[28:16]));
		end
		repeat (24) begin
			w = $urandom | 32'h10000000;
			h.etherType = $urandom_range(1) ? 16'h0800 : 16'h86dd;
			h.ipVersion = $urandom_range(1) ? 4'h4 : 4'h6;
			h.ipv4Ihl = 4'($urandom_range(7, 3));
			h.hdrBytes = $urandom_range(1) ? 8'h28 : {2'h0, h.ipv4Ihl, 2'h0};
			frame($urandom, $urandom);
		end
		check("irq masked", irq, 32'h0);
		regXfer(1'b1, 4'h8, 32'h7);
		repeat (2) @(posedge mclk);
		#1 check("irq", irq, 32'h1);
		regXfer(1'b1, 4'h4, 32'h7);
		repeat (2) @(posedge mclk);
		#1 check("irq clr", irq, 32'h0);
		regXfer(1'b0, 4'h8, 32'h0);
		check("enable", d, 32'h7);
		regXfer(1'b0, 4'hc, 32'h0);
		check("last word", d, w & 32'hfef3ffff);
		final_report();
	end
endmodule // tb
